// >>> hw/filter_accelerator.sv
// filter accelerator: constants package and the mac/alu datapath with its controller
`timescale 1ns/1ps

package filter_pkg;
   localparam int DATA_W = 24;
   localparam int ACC_W = 48;
   localparam int NUM_TAPS = 64;
   localparam int NUM_BANKS = 4;
   localparam int BANK_TAPS = 16;
   localparam int IIR_FWD_TAPS = 8;
   localparam int ACC_RES_HI = 46;
   localparam int ACC_RES_LO = 23;
   localparam int ROUND_BIT = 22;
   localparam int FIFO_DEPTH = 8;
   localparam int ADDR_W = 6;
   localparam int CHAN_W = 2;
   localparam int CTL_W = 18;
   localparam logic [23:0] SAT_POS = 24'h7FFFFF;
   localparam logic [23:0] SAT_NEG = 24'h800000;
   localparam logic [23:0] ONE_LSB = 24'h000001;
   localparam logic [23:0] ALL_ONES = 24'hFFFFFF;

   typedef enum logic [3:0] {
      ALU_PASS, ALU_ADD, ALU_SUB, ALU_CMP, ALU_THRESH, ALU_ABS, ALU_SQUELCH, ALU_SAT
   } alu_op_type;
   typedef enum logic [1:0] {ACC_HOLD, ACC_LOAD, ACC_ADD, ACC_CLEAR} acc_mode_type;
   typedef enum logic [1:0] {WR_NONE, WR_OUT, WR_FB, WR_BOTH} wr_sel_type;

   // seven fields, 6+4+2+2+1+1+2 = 18 bits
   typedef struct packed {
      logic [5:0] addr;
      alu_op_type alu_op;
      logic [1:0] shift;
      acc_mode_type acc_mode;
      logic round;
      logic mac_en;
      wr_sel_type wr_sel;
   } ctl_type;

   typedef enum logic [2:0] {S_IDLE, S_TAPS, S_FINISH, S_OUT} state_type;

   // clamp a 25-bit signed sum into 24 bits
   function automatic logic [23:0] sat24(input logic [24:0] s);
      if (s[24] != s[23]) begin
         sat24 = s[24] ? SAT_NEG : SAT_POS;
      end else begin
         sat24 = s[23:0];
      end
   endfunction

   // first tap address of a 16-tap bank
   function automatic logic [5:0] bank_base(input logic [1:0] chan);
      bank_base = {chan, 4'h0};
   endfunction
endpackage

module filter_accelerator (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic [23:0] in_data,
   input wire logic [1:0] in_chan,
   output logic in_ready,
   output logic out_valid,
   output logic [23:0] out_data,
   output logic [1:0] out_chan,
   input wire logic out_ready,
   input wire logic coef_wr_en,
   input wire logic [5:0] coef_wr_addr,
   input wire logic [23:0] coef_wr_data,
   input wire logic split_mode,
   input wire logic [3:0] iir_mask,
   input wire logic [3:0] alu_op_sel,
   input wire logic [23:0] alu_operand,
   input wire logic [1:0] out_shift,
   input wire logic round_en,
   output logic busy
);
   typedef struct packed {
      filter_pkg::state_type st;
      logic [5:0] cnt;
      logic [5:0] last;
      logic [1:0] chan;
      logic iir;
      filter_pkg::ctl_type ctl;
      logic signed [47:0] acc;
      logic [63:0][23:0] samp;
      logic [63:0][23:0] coef;
      logic [23:0] out_data;
      logic [1:0] out_chan;
      logic out_valid;
      logic busy;
   } top_state_type;

   top_state_type cur_r;
   top_state_type cur_nxt;
   logic fifo_valid;
   logic fifo_pop;
   logic [25:0] fifo_data;

   // inbound samples queue here; a stalled result backs up into in_ready
   sample_fifo #(
      .WIDTH(filter_pkg::DATA_W + filter_pkg::CHAN_W),
      .DEPTH(filter_pkg::FIFO_DEPTH)
   ) u_in_fifo (
      .ref_clk(ref_clk),
      .rst(rst),
      .s_valid(in_valid),
      .s_data({in_chan, in_data}),
      .s_ready(in_ready),
      .m_valid(fifo_valid),
      .m_data(fifo_data),
      .m_ready(fifo_pop)
   );

   assign fifo_pop = (cur_r.st == filter_pkg::S_IDLE);

   // accumulator to 24-bit result with rounding and saturation
   function automatic logic [23:0] acc_to_res(input logic [47:0] a, input logic rnd);
      logic [48:0] t;
      t = {a[47], a} + (rnd ? (49'h1 << filter_pkg::ROUND_BIT) : 49'h0);
      if (t[48:47] != {2{t[46]}}) begin
         acc_to_res = t[48] ? filter_pkg::SAT_NEG : filter_pkg::SAT_POS;
      end else begin
         acc_to_res = t[filter_pkg::ACC_RES_HI:filter_pkg::ACC_RES_LO];
      end
   endfunction

   // post-processing on the 24-bit result against the operand k
   function automatic logic [23:0] alu_calc(input filter_pkg::alu_op_type op,
                                            input logic [23:0] x, input logic [23:0] k);
      logic [23:0] mag;
      logic ge;
      mag = x[23] ? filter_pkg::sat24(25'd0 - {x[23], x}) : x;
      ge = ($signed(x) >= $signed(k));
      unique case (op)
         filter_pkg::ALU_ADD: alu_calc = filter_pkg::sat24({x[23], x} + {k[23], k});
         filter_pkg::ALU_SUB: alu_calc = filter_pkg::sat24({x[23], x} - {k[23], k});
         filter_pkg::ALU_CMP: alu_calc = (x == k) ? 24'h000000
                                         : (ge ? filter_pkg::ONE_LSB : filter_pkg::ALL_ONES);
         filter_pkg::ALU_THRESH: alu_calc = ge ? filter_pkg::SAT_POS : 24'h000000;
         filter_pkg::ALU_ABS: alu_calc = mag;
         filter_pkg::ALU_SQUELCH: alu_calc = ($signed(mag) < $signed(k)) ? 24'h000000 : x;
         filter_pkg::ALU_SAT: alu_calc = ($signed(x) > $signed(k)) ? k
                                         : (($signed(x) < -$signed(k)) ? 24'(-$signed(k)) : x);
         default: alu_calc = x; // pass and unused op codes
      endcase
   endfunction

   // controller and datapath as one next-state computation
   always_comb begin
      logic [5:0] base;
      logic [6:0] nff;
      logic [47:0] prod;
      logic [23:0] res;
      logic [23:0] y;
      logic [1:0] ch;
      logic fb_wr;
      base = 6'h00;
      nff = 7'h00;
      prod = 48'h0;
      res = 24'h0;
      y = 24'h0;
      ch = 2'h0;
      fb_wr = 1'b0;
      cur_nxt = cur_r;
      cur_nxt.ctl = '0;

      // coefficient loads; writes while busy take effect mid-output
      if (coef_wr_en) begin
         cur_nxt.coef[coef_wr_addr] = coef_wr_data;
      end

      // output handshake before any new result is posted
      if (cur_r.out_valid && out_ready) begin
         cur_nxt.out_valid = 1'b0;
      end

      unique case (cur_r.st)
         filter_pkg::S_IDLE: begin
            if (fifo_valid) begin
               ch = split_mode ? fifo_data[25:24] : 2'h0;
               base = filter_pkg::bank_base(ch);
               cur_nxt.chan = ch;
               cur_nxt.iir = split_mode && iir_mask[ch];
               nff = !split_mode ? 7'(filter_pkg::NUM_TAPS)
                     : (iir_mask[ch] ? 7'(filter_pkg::IIR_FWD_TAPS)
                        : 7'(filter_pkg::BANK_TAPS));
               // shift the bank's input delay line, newest sample at the bank base
               for (int i = filter_pkg::NUM_TAPS - 1; i >= 0; i--) begin
                  if (i >= base && i < base + nff) begin
                     cur_nxt.samp[i] = (i == base) ? fifo_data[23:0] : cur_r.samp[6'(i - 1)];
                  end
               end
               cur_nxt.last = split_mode ? 6'(filter_pkg::BANK_TAPS - 1)
                              : 6'(filter_pkg::NUM_TAPS - 1);
               cur_nxt.cnt = 6'h00;
               cur_nxt.st = filter_pkg::S_TAPS;
            end
         end
         filter_pkg::S_TAPS: begin
            // one tap issued per clock, the first one reloads the accumulator
            cur_nxt.ctl.addr = filter_pkg::bank_base(cur_r.chan) + cur_r.cnt;
            cur_nxt.ctl.mac_en = 1'b1;
            cur_nxt.ctl.acc_mode = (cur_r.cnt == 6'h00) ? filter_pkg::ACC_LOAD
                                   : filter_pkg::ACC_ADD;
            cur_nxt.cnt = cur_r.cnt + 6'h01;
            if (cur_r.cnt == cur_r.last) begin
               cur_nxt.st = filter_pkg::S_FINISH;
            end
         end
         filter_pkg::S_FINISH: begin
            // last product lands this cycle; alu stage issued for the next
            cur_nxt.ctl.acc_mode = filter_pkg::ACC_HOLD;
            cur_nxt.ctl.alu_op = filter_pkg::alu_op_type'(alu_op_sel);
            cur_nxt.ctl.shift = out_shift;
            cur_nxt.ctl.round = round_en;
            cur_nxt.ctl.wr_sel = cur_r.iir ? filter_pkg::WR_BOTH : filter_pkg::WR_OUT;
            cur_nxt.st = filter_pkg::S_OUT;
         end
         filter_pkg::S_OUT: begin
            if (cur_r.out_valid && out_ready) begin
               cur_nxt.st = filter_pkg::S_IDLE;
            end
         end
         default: cur_nxt.st = filter_pkg::S_IDLE;
      endcase

      // mac stage, steered by the registered control word
      if (cur_r.ctl.mac_en) begin
         prod = 48'($signed(cur_r.samp[cur_r.ctl.addr]) * $signed(cur_r.coef[cur_r.ctl.addr]));
      end
      unique case (cur_r.ctl.acc_mode)
         filter_pkg::ACC_LOAD: cur_nxt.acc = prod;
         filter_pkg::ACC_ADD: cur_nxt.acc = cur_r.acc + prod;
         filter_pkg::ACC_CLEAR: cur_nxt.acc = 48'h0;
         filter_pkg::ACC_HOLD: cur_nxt.acc = cur_r.acc;
      endcase

      // alu stage: round, scale down, post-process, then route the result
      if (cur_r.ctl.wr_sel != filter_pkg::WR_NONE) begin
         res = acc_to_res(cur_r.acc, cur_r.ctl.round);
         res = 24'($signed(res) >>> cur_r.ctl.shift);
         y = alu_calc(cur_r.ctl.alu_op, res, alu_operand);
         cur_nxt.out_data = y;
         cur_nxt.out_chan = cur_r.chan;
         cur_nxt.out_valid = 1'b1;
         fb_wr = (cur_r.ctl.wr_sel == filter_pkg::WR_BOTH);
      end
      // iir banks keep their past outputs in the upper half of the bank
      if (fb_wr) begin
         base = filter_pkg::bank_base(cur_r.chan) + 6'(filter_pkg::IIR_FWD_TAPS);
         for (int i = filter_pkg::NUM_TAPS - 1; i >= 0; i--) begin
            if (i >= base && i < base + filter_pkg::IIR_FWD_TAPS) begin
               cur_nxt.samp[i] = (i == base) ? y : cur_r.samp[6'(i - 1)];
            end
         end
      end
      cur_nxt.busy = (cur_nxt.st != filter_pkg::S_IDLE);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cur_r <= '0;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   assign out_valid = cur_r.out_valid;
   assign out_data = cur_r.out_data;
   assign out_chan = cur_r.out_chan;
   assign busy = cur_r.busy;
endmodule

// >>> hw/sample_fifo.sv
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps

module sample_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic s_valid,
   input wire logic [WIDTH-1:0] s_data,
   output logic s_ready,
   output logic m_valid,
   output logic [WIDTH-1:0] m_data,
   input wire logic m_ready
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   // refuse shapes the pointer logic cannot serve
   if (DEPTH < 2 || WIDTH < 1) begin : g_bad_shape
      $error("sample_fifo needs DEPTH >= 2 and WIDTH >= 1");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
      logic ready;
   } fifo_state_type;

   fifo_state_type cur_r;
   fifo_state_type cur_nxt;
   logic push;
   logic pop;

   // ready is registered so the top can drive it straight from a flop
   always_comb begin
      cur_nxt = cur_r;
      push = s_valid && cur_r.ready;
      pop = (cur_r.cnt != '0) && m_ready;
      if (push) begin
         cur_nxt.mem[cur_r.wp] = s_data;
         cur_nxt.wp = (cur_r.wp == PW'(DEPTH - 1)) ? '0 : cur_r.wp + 1'b1;
      end
      if (pop) begin
         cur_nxt.rp = (cur_r.rp == PW'(DEPTH - 1)) ? '0 : cur_r.rp + 1'b1;
      end
      cur_nxt.cnt = cur_r.cnt + CW'(push) - CW'(pop);
      cur_nxt.ready = (cur_nxt.cnt != CW'(DEPTH));
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cur_r <= '0;
         cur_r.ready <= 1'b1;
      end else begin
         cur_r <= cur_nxt;
      end
   end

   assign s_ready = cur_r.ready;
   assign m_valid = (cur_r.cnt != '0);
   assign m_data = cur_r.mem[cur_r.rp];
endmodule

// >>> testbench/filter_accelerator_asserts.sv
// port-level assertions for the filter accelerator
`timescale 1ns/1ps
module filter_accelerator_asserts (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic in_ready,
   input wire logic out_valid,
   input wire logic [23:0] out_data,
   input wire logic [1:0] out_chan,
   input wire logic out_ready,
   input wire logic split_mode,
   input wire logic busy
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // a stalled result must not move under the consumer
   property p_hold;
      out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_chan);
   endproperty
   a_hold: assert property (p_hold) else $error("result moved while stalled");
   property p_drop;
      out_valid && out_ready |=> !out_valid && !busy;
   endproperty
   a_drop: assert property (p_drop) else $error("no idle cycle after take");
   property p_busy;
      out_valid |-> busy;
   endproperty
   a_busy: assert property (p_busy) else $error("result while idle");
   property p_chan;
      out_valid && !split_mode |-> out_chan == 2'h0;
   endproperty
   a_chan: assert property (p_chan) else $error("bank set in single mode");
   property p_rst;
      $fell(rst) |-> in_ready && !out_valid && !busy;
   endproperty
   a_rst: assert property (p_rst) else $error("bad state after reset");
   // 16 taps then finish and alu: one tap per cycle fixes the span
   property p_lat16;
      $rose(busy) && split_mode |-> !out_valid [*8] ##11 $rose(out_valid);
   endproperty
   a_lat16: assert property (p_lat16) else $error("16-tap latency off");
   property p_lat64;
      $rose(busy) && !split_mode |-> ##66 $rose(out_valid);
   endproperty
   a_lat64: assert property (p_lat64) else $error("64-tap latency off");
   // a full buffer seen in the idle cycle frees a slot with that cycle's pop
   property p_full;
      !in_ready && !busy |=> in_ready;
   endproperty
   a_full: assert property (p_full) else $error("buffer full while idle");
   c_take: cover property (out_valid && out_ready);
   c_stall: cover property (out_valid && !out_ready);
   c_full: cover property (!in_ready);
endmodule
bind filter_accelerator filter_accelerator_asserts chk_u (.ref_clk(ref_clk), .rst(rst),
   .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_chan(out_chan),
   .out_ready(out_ready), .split_mode(split_mode), .busy(busy));

// >>> testbench/result_sink.sv
// result consumer model with stall and half-rate pacing
`timescale 1ns/1ps
module result_sink (
   input wire logic ref_clk,
   input wire logic out_valid,
   input wire logic [23:0] out_data,
   input wire logic [1:0] out_chan,
   input wire logic stall,
   input wire logic slow,
   output logic out_ready
);
   logic [25:0] got_q[$];
   initial out_ready = 1'b0;
   // take on ready and valid; slow pacing drops ready every other cycle
   always @(posedge ref_clk) begin
      if (out_valid && out_ready) got_q.push_back({out_chan, out_data});
      out_ready <= #1 !stall && !(slow && out_ready);
   end
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for the filter accelerator
`timescale 1ns/1ps
module tb_top;
   logic ref_clk = 1'b0, rst = 1'b1, in_valid = 1'b0, coef_wr_en = 1'b0, split_mode = 1'b0;
   logic round_en = 1'b0, stall = 1'b0, slow = 1'b0, out_ready, in_ready, out_valid, busy;
   logic [23:0] in_data = 24'h000000, coef_wr_data = 24'h000000, alu_operand = 24'h000000;
   logic [1:0] in_chan = 2'h0, out_shift = 2'h0, out_chan;
   logic [5:0] coef_wr_addr = 6'h00;
   logic [3:0] iir_mask = 4'h0, alu_op_sel = 4'h0;
   logic [23:0] out_data, hs[64], cf[64];
   int n_mismatch = 0, tests_run = 0;
   always #2.5 ref_clk = ~ref_clk;
   filter_accelerator dut_u (
      .ref_clk(ref_clk), .rst(rst), .in_valid(in_valid), .in_data(in_data), .in_chan(in_chan),
      .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_chan(out_chan),
      .out_ready(out_ready), .coef_wr_en(coef_wr_en), .coef_wr_addr(coef_wr_addr),
      .coef_wr_data(coef_wr_data), .split_mode(split_mode), .iir_mask(iir_mask),
      .alu_op_sel(alu_op_sel), .alu_operand(alu_operand), .out_shift(out_shift),
      .round_en(round_en), .busy(busy)
   );
   result_sink sink_u (
      .ref_clk(ref_clk), .out_valid(out_valid), .out_data(out_data), .out_chan(out_chan),
      .stall(stall), .slow(slow), .out_ready(out_ready)
   );
   // clamp a wide sum into 24 signed bits
   function automatic logic [23:0] clip(input logic signed [24:0] s);
      return (s[24] != s[23]) ? (s[24] ? filter_pkg::SAT_NEG : filter_pkg::SAT_POS) : s[23:0];
   endfunction
   // reference: shift delay line, mac, round, pick 46:23, shift, alu, feedback
   function automatic logic [23:0] ref_push(input logic [23:0] x, input int b, input int n,
      input bit iir);
      logic signed [48:0] acc;
      logic signed [23:0] y;
      logic signed [23:0] k;
      acc = '0;
      k = alu_operand;
      for (int i = (iir ? 7 : n - 1); i > 0; i--) hs[b + i] = hs[b + i - 1];
      hs[b] = x;
      for (int i = 0; i < n; i++) acc += $signed(hs[b + i]) * $signed(cf[b + i]);
      if (round_en) acc += 49'sh400000;
      y = (acc[48:46] == 3'h0 || acc[48:46] == 3'h7) ? acc[46:23]
         : (acc[48] ? filter_pkg::SAT_NEG : filter_pkg::SAT_POS);
      y = y >>> out_shift;
      case (alu_op_sel)
         4'h1: y = clip(y + k);
         4'h2: y = clip(y - k);
         4'h3: y = (y > k) ? 24'h000001 : ((y == k) ? 24'h000000 : 24'hFFFFFF);
         4'h4: y = (y >= k) ? 24'h7FFFFF : 24'h000000;
         4'h5: y = clip(y[23] ? -y : y);
         4'h6: y = ((y[23] ? -y : y) < k) ? 24'h000000 : y;
         4'h7: y = (y > k) ? k : ((y < -k) ? -k : y);
         default: ;
      endcase
      if (iir) begin
         for (int i = 7; i > 0; i--) hs[b + 8 + i] = hs[b + 7 + i];
         hs[b + 8] = y;
      end
      return y;
   endfunction
   task automatic chk(input logic [25:0] got, input logic [25:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // reset also clears both memories, so the reference starts from zero
   task automatic do_reset();
      rst = 1'b1;
      repeat (20) @(posedge ref_clk);
      #1 rst = 1'b0;
      foreach (hs[i]) hs[i] = '0;
      foreach (cf[i]) cf[i] = '0;
      @(posedge ref_clk) #1; // first request one cycle after release
   endtask
   task automatic wcoef(input int a, input logic [23:0] d);
      coef_wr_en = 1'b1;
      coef_wr_addr = a[5:0];
      coef_wr_data = d;
      cf[a] = d;
      @(posedge ref_clk) #1;
      coef_wr_en = 1'b0;
      @(posedge ref_clk) #1; // let an edge pass so a following write starts cleanly
   endtask
   // offer one word and hold it until the buffer takes it
   task automatic send(input logic [23:0] x, input logic [1:0] ch);
      in_valid = 1'b1;
      in_data = x;
      in_chan = ch;
      while (in_ready !== 1'b1) @(posedge ref_clk) #1;
      @(posedge ref_clk) #1;
      in_valid = 1'b0;
   endtask
   task automatic expect_out(input logic [23:0] x, input logic [1:0] ch);
      logic [23:0] y;
      y = ref_push(x, split_mode ? 16 * ch : 0, split_mode ? filter_pkg::BANK_TAPS
         : filter_pkg::NUM_TAPS, split_mode && iir_mask[ch]);
      // resume off the edge so the next stimulus never races the sampling edge
      for (int i = 0; i < 300 && sink_u.got_q.size() == 0; i++) @(posedge ref_clk) #1;
      chk(sink_u.got_q.size() != 0 ? sink_u.got_q.pop_front() : {26{1'bx}},
         {split_mode ? ch : 2'h0, y});
   endtask
   // every alu code on -0.5 * 0.5 with operand 0.125
   task automatic t_alu();
      split_mode = 1'b1;
      wcoef(0, 24'h400000);
      alu_operand = 24'h100000;
      for (int op = 0; op < 8; op++) begin
         alu_op_sel = op[3:0];
         send(24'hC00000, 2'h0);
         expect_out(24'hC00000, 2'h0);
      end
      $display("alu test done");
   endtask
   // bank 2 recursive with rounding and output shift
   task automatic t_iir();
      alu_op_sel = 4'h0;
      iir_mask = 4'h4;
      round_en = 1'b1;
      out_shift = 2'h1;
      wcoef(32, 24'h400000);
      wcoef(40, 24'h400000);
      for (int i = 0; i < 4; i++) begin
         send(24'h200001, 2'h2);
         expect_out(24'h200001, 2'h2);
      end
      $display("iir test done");
   endtask
   // consumer stalls: one word in the engine, eight buffered, the tenth refused
   task automatic t_fill();
      int n;
      logic taken;
      n = 0;
      stall = 1'b1;
      in_valid = 1'b1;
      for (int c = 0; c < 40 && n < 10; c++) begin
         in_data = 24'h123457 * (n + 1);
         in_chan = n[1:0];
         taken = in_ready;
         @(posedge ref_clk) #1;
         n += taken;
      end
      in_valid = 1'b0;
      chk(n, 26'h9);
      stall = 1'b0;
      for (int i = 0; i < 9; i++) expect_out(24'h123457 * (i + 1), i[1:0]);
      $display("fill test done");
   endtask
   // one long filter through all 64 pairs, slow consumer, bank input ignored
   task automatic t_fir64();
      split_mode = 1'b0;
      slow = 1'b1;
      wcoef(0, 24'h400000);
      wcoef(63, 24'h7FFFFF);
      wcoef(31, 24'hA00000);
      for (int i = 0; i < 66; i++) begin
         send(24'h0A3D71 * i, 2'h3);
         expect_out(24'h0A3D71 * i, 2'h3);
      end
      $display("fir64 test done");
   endtask
   initial begin
      do_reset();
      chk({23'h0, in_ready, out_valid, busy}, 26'h4);
      t_alu();
      t_iir();
      t_fill();
      do_reset();
      t_fir64();
      wrap_up();
   end
   // hang guard well beyond the expected run length
   initial begin
      #100000;
      n_mismatch++;
      wrap_up();
   end
endmodule
